// File: oic_command_port.sv
`timescale 1ns/1ns
module oic_command_port (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           scl_in,
  output logic                                scl_out,
  output logic                                scl_oe,
  input  wire logic                           sda_in,
  output logic                                sda_out,
  output logic                                sda_oe,
  input  wire logic                           addr_select_pin,
  output logic                                ram_wr_en,
  output logic [oic_pkg::COL_WIDTH-1:0]       ram_wr_addr,
  output logic [7:0]                          ram_wr_data,
  input  wire logic                           ram_wr_ready,
  output logic                                cmd_valid,
  output logic [7:0]                          cmd_byte,
  output logic [7:0]                          contrast_level,
  output logic                                oled_cmdset_enable
);

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic [1:0] sel_sync_r;
  logic       scl_prev_r;
  logic       sda_prev_r;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      sel_sync_r <= 2'h0;
      scl_prev_r <= 1'h1;
      sda_prev_r <= 1'h1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      sel_sync_r <= {sel_sync_r[0], addr_select_pin};
      scl_prev_r <= scl_sync_r[1];
      sda_prev_r <= sda_sync_r[1];
    end
  end

  always_comb begin
    scl_s      = scl_sync_r[1];
    sda_s      = sda_sync_r[1];
    scl_rise   = scl_s && !scl_prev_r;
    scl_fall   = !scl_s && scl_prev_r;
    start_cond = scl_s && scl_prev_r && sda_prev_r && !sda_s;
    stop_cond  = scl_s && scl_prev_r && !sda_prev_r && sda_s;
  end

  // ----------------------------------------------------------------------
  // Received word buffer
  // ----------------------------------------------------------------------
  oic_stream_if #(.WIDTH(oic_pkg::WORD_WIDTH)) rx_if ();
  oic_stream_if #(.WIDTH(oic_pkg::WORD_WIDTH)) dec_if ();

  oic_fifo #(
    .WIDTH (oic_pkg::WORD_WIDTH),
    .DEPTH (oic_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk (clk),
    .rst (rst),
    .wr  (rx_if.snk),
    .rd  (dec_if.src)
  );

  // ----------------------------------------------------------------------
  // Bus protocol engine
  // ----------------------------------------------------------------------
  oic_pkg::oic_state_e state_r;
  oic_pkg::oic_state_e state_nxt;
  logic [3:0]          cnt_r;
  logic [3:0]          cnt_nxt;
  logic [7:0]          shift_r;
  logic [7:0]          shift_nxt;
  logic                rw_r;
  logic                rw_nxt;
  logic                expect_ctrl_r;
  logic                expect_ctrl_nxt;
  logic                stream_r;
  logic                stream_nxt;
  logic                dc_r;
  logic                dc_nxt;
  logic                sda_oe_r;
  logic                sda_oe_nxt;
  logic                push_r;
  logic                push_nxt;
  logic [8:0]          push_data_r;
  logic [8:0]          push_data_nxt;
  logic [7:0]          status_byte;
  logic [6:0]          own_addr;
  logic                oled_cmdset_enable_r;
  logic [6:0]          col_r;

  always_comb begin
    state_nxt       = state_r;
    cnt_nxt         = cnt_r;
    shift_nxt       = shift_r;
    rw_nxt          = rw_r;
    expect_ctrl_nxt = expect_ctrl_r;
    stream_nxt      = stream_r;
    dc_nxt          = dc_r;
    sda_oe_nxt      = sda_oe_r;
    push_nxt        = push_r;
    push_data_nxt   = push_data_r;
    own_addr        = {oic_pkg::ADDR_UPPER, sel_sync_r[1]};
    status_byte     = {oled_cmdset_enable_r, col_r};
    if (push_r && rx_if.ready) begin
      push_nxt = 1'h0;
    end
    if (start_cond) begin
      state_nxt  = oic_pkg::ST_ADDR;
      cnt_nxt    = oic_pkg::BIT_NONE;
      sda_oe_nxt = 1'h0;
    end else if (stop_cond) begin
      state_nxt  = oic_pkg::ST_IDLE;
      sda_oe_nxt = 1'h0;
    end else begin
      case (state_r)
        oic_pkg::ST_IDLE: begin
          sda_oe_nxt = 1'h0;
        end
        oic_pkg::ST_ADDR, oic_pkg::ST_RX: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_s};
            cnt_nxt   = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == oic_pkg::BIT_LAST) begin
            if (state_r == oic_pkg::ST_ADDR) begin
              if (shift_r[7:1] == own_addr) begin
                rw_nxt     = shift_r[0];
                sda_oe_nxt = 1'h1;
                state_nxt  = oic_pkg::ST_ADDR_ACK;
              end else begin
                state_nxt = oic_pkg::ST_IDLE;
              end
            end else begin
              sda_oe_nxt = 1'h1;
              state_nxt  = oic_pkg::ST_RX_ACK;
              if (expect_ctrl_r) begin
                dc_nxt          = shift_r[oic_pkg::DC_BIT];
                expect_ctrl_nxt = 1'h0;
                stream_nxt      = !shift_r[oic_pkg::CO_BIT];
              end else begin
                push_nxt        = 1'h1;
                push_data_nxt   = {dc_r, shift_r};
                expect_ctrl_nxt = !stream_r;
              end
            end
          end
        end
        oic_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_r == oic_pkg::RW_READ) begin
              shift_nxt  = status_byte;
              sda_oe_nxt = !status_byte[oic_pkg::MSB_BIT];
              cnt_nxt    = oic_pkg::BIT_FIRST_TX;
              state_nxt  = oic_pkg::ST_TX;
            end else begin
              sda_oe_nxt      = 1'h0;
              cnt_nxt         = oic_pkg::BIT_NONE;
              expect_ctrl_nxt = 1'h1;
              stream_nxt      = 1'h0;
              state_nxt       = oic_pkg::ST_RX;
            end
          end
        end
        oic_pkg::ST_RX_ACK: begin
          if (scl_fall) begin
            sda_oe_nxt = 1'h0;
            cnt_nxt    = oic_pkg::BIT_NONE;
            state_nxt  = oic_pkg::ST_RX;
          end
        end
        oic_pkg::ST_TX: begin
          if (scl_fall) begin
            if (cnt_r == oic_pkg::BIT_LAST) begin
              sda_oe_nxt = 1'h0;
              state_nxt  = oic_pkg::ST_TX_ACK;
            end else begin
              shift_nxt  = {shift_r[6:0], 1'h0};
              sda_oe_nxt = !shift_r[6];
              cnt_nxt    = cnt_r + 4'h1;
            end
          end
        end
        oic_pkg::ST_TX_ACK: begin
          if (scl_rise && sda_s) begin
            state_nxt = oic_pkg::ST_IDLE;
          end else if (scl_fall) begin
            shift_nxt  = status_byte;
            sda_oe_nxt = !status_byte[oic_pkg::MSB_BIT];
            cnt_nxt    = oic_pkg::BIT_FIRST_TX;
            state_nxt  = oic_pkg::ST_TX;
          end
        end
        default: begin
          state_nxt  = oic_pkg::ST_IDLE;
          sda_oe_nxt = 1'h0;
        end
      endcase
    end
    rx_if.valid = push_r;
    rx_if.data  = push_data_r;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r       <= oic_pkg::ST_IDLE;
      cnt_r         <= oic_pkg::BIT_NONE;
      shift_r       <= 8'h00;
      rw_r          <= 1'h0;
      expect_ctrl_r <= 1'h1;
      stream_r      <= 1'h0;
      dc_r          <= 1'h0;
      sda_oe_r      <= 1'h0;
      push_r        <= 1'h0;
      push_data_r   <= 9'h000;
    end else begin
      state_r       <= state_nxt;
      cnt_r         <= cnt_nxt;
      shift_r       <= shift_nxt;
      rw_r          <= rw_nxt;
      expect_ctrl_r <= expect_ctrl_nxt;
      stream_r      <= stream_nxt;
      dc_r          <= dc_nxt;
      sda_oe_r      <= sda_oe_nxt;
      push_r        <= push_nxt;
      push_data_r   <= push_data_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Clock stretch from each data byte's acknowledge until the buffer takes the byte
  // ----------------------------------------------------------------------
  logic scl_oe_r;
  logic scl_oe_nxt;

  always_comb begin
    scl_oe_nxt = (state_nxt == oic_pkg::ST_RX_ACK) && push_nxt &&
                 !scl_s;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_oe_r <= 1'h0;
    end else begin
      scl_oe_r <= scl_oe_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Command and data decoder
  // ----------------------------------------------------------------------
  logic       oled_cmdset_enable_nxt;
  logic [7:0] contrast_r;
  logic [7:0] contrast_nxt;
  logic       contrast_pend_r;
  logic       contrast_pend_nxt;
  logic [6:0] col_nxt;
  logic       ram_wr_en_r;
  logic       ram_wr_en_nxt;
  logic [6:0] ram_wr_addr_r;
  logic [6:0] ram_wr_addr_nxt;
  logic [7:0] ram_wr_data_r;
  logic [7:0] ram_wr_data_nxt;
  logic       cmd_valid_r;
  logic       cmd_valid_nxt;
  logic [7:0] cmd_byte_r;
  logic [7:0] cmd_byte_nxt;
  logic       take;
  logic       word_dc;
  logic [7:0] word_byte;

  always_comb begin
    oled_cmdset_enable_nxt = oled_cmdset_enable_r;
    contrast_nxt           = contrast_r;
    contrast_pend_nxt      = contrast_pend_r;
    col_nxt                = col_r;
    ram_wr_en_nxt          = ram_wr_en_r && !ram_wr_ready;
    ram_wr_addr_nxt        = ram_wr_addr_r;
    ram_wr_data_nxt        = ram_wr_data_r;
    cmd_valid_nxt          = 1'h0;
    cmd_byte_nxt           = cmd_byte_r;
    dec_if.ready           = !(ram_wr_en_r && !ram_wr_ready);
    take                   = dec_if.valid && dec_if.ready;
    word_dc                = dec_if.data[8];
    word_byte              = dec_if.data[7:0];
    if (take) begin
      if (word_dc) begin
        ram_wr_en_nxt   = 1'h1;
        ram_wr_addr_nxt = col_r;
        ram_wr_data_nxt = word_byte;
        col_nxt         = col_r + oic_pkg::COL_STEP;
      end else if (contrast_pend_r) begin
        contrast_pend_nxt = 1'h0;
        contrast_nxt      = (word_byte == oic_pkg::CONTRAST_ZERO) ?
                            oic_pkg::CONTRAST_MIN : word_byte;
      end else begin
        cmd_valid_nxt = 1'h1;
        cmd_byte_nxt  = word_byte;
        if (word_byte == oic_pkg::CMD_OLED_ON) begin
          oled_cmdset_enable_nxt = 1'h1;
        end else if (word_byte == oic_pkg::CMD_OLED_OFF) begin
          oled_cmdset_enable_nxt = 1'h0;
        end else if (word_byte == oic_pkg::CMD_CONTRAST &&
                     oled_cmdset_enable_r) begin
          contrast_pend_nxt = 1'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oled_cmdset_enable_r <= 1'h0;
      contrast_r           <= oic_pkg::CONTRAST_RST;
      contrast_pend_r      <= 1'h0;
      col_r                <= oic_pkg::COL_RST;
      ram_wr_en_r          <= 1'h0;
      ram_wr_addr_r        <= oic_pkg::COL_RST;
      ram_wr_data_r        <= 8'h00;
      cmd_valid_r          <= 1'h0;
      cmd_byte_r           <= 8'h00;
    end else begin
      oled_cmdset_enable_r <= oled_cmdset_enable_nxt;
      contrast_r           <= contrast_nxt;
      contrast_pend_r      <= contrast_pend_nxt;
      col_r                <= col_nxt;
      ram_wr_en_r          <= ram_wr_en_nxt;
      ram_wr_addr_r        <= ram_wr_addr_nxt;
      ram_wr_data_r        <= ram_wr_data_nxt;
      cmd_valid_r          <= cmd_valid_nxt;
      cmd_byte_r           <= cmd_byte_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  logic drive_low_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_low_r <= 1'h0;
    end else begin
      drive_low_r <= 1'h0;
    end
  end

  always_comb begin
    scl_out            = drive_low_r;
    scl_oe             = scl_oe_r;
    sda_out            = drive_low_r;
    sda_oe             = sda_oe_r;
    ram_wr_en          = ram_wr_en_r;
    ram_wr_addr        = ram_wr_addr_r;
    ram_wr_data        = ram_wr_data_r;
    cmd_valid          = cmd_valid_r;
    cmd_byte           = cmd_byte_r;
    contrast_level     = contrast_r;
    oled_cmdset_enable = oled_cmdset_enable_r;
  end
endmodule

// File: oic_command_port_asserts.sv
`timescale 1ns/1ns
module oic_command_port_asserts (
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic                          scl_in,
  input wire logic                          scl_out,
  input wire logic                          scl_oe,
  input wire logic                          sda_in,
  input wire logic                          sda_out,
  input wire logic                          sda_oe,
  input wire logic                          addr_select_pin,
  input wire logic                          ram_wr_en,
  input wire logic [oic_pkg::COL_WIDTH-1:0] ram_wr_addr,
  input wire logic [7:0]                    ram_wr_data,
  input wire logic                          ram_wr_ready,
  input wire logic                          cmd_valid,
  input wire logic [7:0]                    cmd_byte,
  input wire logic [7:0]                    contrast_level,
  input wire logic                          oled_cmdset_enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_ram_wait;
    ram_wr_en && !ram_wr_ready;
  endsequence

  sequence s_ram_accept;
    ram_wr_en && ram_wr_ready;
  endsequence

  a_ram_hold: assert property (
    s_ram_wait |=> ram_wr_en && $stable(ram_wr_addr) && $stable(ram_wr_data))
    else $error("ram write changed before it was taken");
  a_col_step: assert property (
    s_ram_accept |=> !ram_wr_en || ram_wr_addr == $past(ram_wr_addr) + 7'h01)
    else $error("column did not advance by one");
  a_cmd_pulse: assert property (
    cmd_valid |=> !cmd_valid)
    else $error("command strobe longer than one cycle");
  a_set_on: assert property (
    cmd_valid && cmd_byte == 8'h79 |-> ##[0:2] oled_cmdset_enable)
    else $error("enable command ignored");
  a_set_off: assert property (
    cmd_valid && cmd_byte == 8'h78 |-> ##[0:2] !oled_cmdset_enable)
    else $error("disable command ignored");
  a_enable_cause: assert property (
    $rose(oled_cmdset_enable) |-> cmd_byte == 8'h79)
    else $error("command set enabled without its command");
  a_contrast_gate: assert property (
    $changed(contrast_level) |-> oled_cmdset_enable)
    else $error("contrast changed while command set disabled");
  a_contrast_floor: assert property (
    contrast_level != 8'h00)
    else $error("contrast left its range");
  a_ack_scl_low: assert property (
    $rose(sda_oe) |-> !scl_in)
    else $error("data line pulled while clock high");
  a_stretch_low: assert property (
    $rose(scl_oe) |-> !scl_in)
    else $error("clock stretch began while clock high");
endmodule

bind oic_command_port oic_command_port_asserts u_asserts (
  .clk, .rst, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe,
  .addr_select_pin, .ram_wr_en, .ram_wr_addr, .ram_wr_data,
  .ram_wr_ready, .cmd_valid, .cmd_byte, .contrast_level,
  .oled_cmdset_enable
);

// File: oic_command_port_tb.sv
`timescale 1ns/1ns
module oic_command_port_tb;
  logic                          clk, rst, addr_select_pin, ram_wr_ready;
  logic                          scl_out, scl_oe, sda_out, sda_oe;
  logic                          ram_wr_en, cmd_valid, oled_cmdset_enable;
  logic [oic_pkg::COL_WIDTH-1:0] ram_wr_addr, col;
  logic [7:0]                    ram_wr_data, cmd_byte, contrast_level;
  logic [7:0]                    con_x, rd, b[$];
  logic [14:0]                   cmdq[$], expc[$], ramq[$], expr[$];
  logic [31:0]                   seed;
  logic [31:0]                   rs = 32'h4eac7498;
  logic                          en_x, ack, stall, d;
  int                            failures, comparisons, stretch_n, n0;
  wire                           h_scl, h_sda;
  wire scl_in = (scl_oe ? scl_out : 1'b1) & !h_scl;
  wire sda_in = (sda_oe ? sda_out : 1'b1) & !h_sda;

  oic_command_port u_dut (
    .clk, .rst, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe,
    .addr_select_pin, .ram_wr_en, .ram_wr_addr, .ram_wr_data,
    .ram_wr_ready, .cmd_valid, .cmd_byte, .contrast_level,
    .oled_cmdset_enable
  );
  oic_host_model u_host (
    .clk, .scl(scl_in), .sda(sda_in), .scl_oe(h_scl), .sda_oe(h_sda)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic roll();
    seed = xs(seed);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Works out the commands, writes and settings a transfer should cause.
  task automatic model(input logic [7:0] v[$]);
    logic ctl, co, dc, pend;
    ctl = 1'b1;
    pend = 1'b0;
    foreach (v[i]) begin
      if (ctl) begin
        co = v[i][7];
        dc = v[i][6];
        ctl = 1'b0;
      end else begin
        ctl = co;
        if (dc) begin
          expr.push_back({col, v[i]});
          col++;
        end else if (pend) begin
          con_x = (v[i] == 8'h00) ? 8'h01 : v[i];
          pend = 1'b0;
        end else begin
          expc.push_back(15'(v[i]));
          if (v[i] == 8'h79) en_x = 1'b1;
          if (v[i] == 8'h78) en_x = 1'b0;
          pend = en_x && v[i] == 8'h81;
        end
      end
    end
  endtask

  task automatic drain(ref logic [14:0] q[$], ref logic [14:0] e[$]);
    int n;
    n = 0;
    while (q.size() < e.size() && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk(q.size(), e.size());
    foreach (e[i]) if (i < q.size()) chk(q[i], e[i]);
    q = {};
    e = {};
  endtask

  task automatic xfer(input logic [7:0] v[$]);
    model(v);
    u_host.start();
    u_host.put({7'h3c + 7'(addr_select_pin), 1'b0}, ack);
    chk(ack, 1);
    foreach (v[i]) begin
      u_host.put(v[i], ack);
      chk(ack, 1);
    end
    u_host.stop();
    repeat (20) @(negedge clk);
    drain(cmdq, expc);
    drain(ramq, expr);
    chk(contrast_level, con_x);
    chk(oled_cmdset_enable, en_x);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(negedge clk) begin
    rs = xs(rs);
    ram_wr_ready <= !stall && rs[1:0] != 2'h0;
  end

  always @(posedge clk) begin
    if (cmd_valid === 1'b1) cmdq.push_back(15'(cmd_byte));
    if (ram_wr_en === 1'b1 && ram_wr_ready === 1'b1)
      ramq.push_back({ram_wr_addr, ram_wr_data});
    if (scl_oe === 1'b1) stretch_n++;
  end

  initial begin
    repeat (95000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    addr_select_pin = 1'b0;
    stall = 1'b0;
    seed = 32'h4eac7498;
    en_x = 1'b0;
    con_x = 8'h7f;
    col = '0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    xfer('{8'h00, 8'h08, 8'h2a, 8'h71, 8'h4c, 8'h72, 8'h00, 8'h79, 8'h81,
           8'h28, 8'hd5, 8'h60, 8'h78, 8'h28, 8'h02, 8'h06, 8'h01,
           8'h0c});
    xfer('{8'h00, 8'h81, 8'h55, 8'h79, 8'h81, 8'h00});
    xfer('{8'h80, 8'h81, 8'h80, 8'hff, 8'hc0, 8'h3c, 8'h80, 8'h78});
    for (int t = 0; t < 6; t++) begin
      roll();
      addr_select_pin = seed[0];
      b = {};
      for (int k = 0; k < 3; k++) begin
        roll();
        b.push_back({1'b1, seed[8], 6'h00});
        b.push_back(seed[8] ? seed[7:0] : {1'b0, seed[6:0]});
      end
      roll();
      d = seed[9];
      b.push_back({1'b0, d, 6'h00});
      for (int k = 0; k < 4; k++) begin
        roll();
        b.push_back(d ? seed[7:0] : {1'b0, seed[6:0]});
      end
      xfer(b);
    end
    stall = 1'b1;
    n0 = stretch_n;
    fork
      begin
        repeat (5000) @(negedge clk);
        stall = 1'b0;
      end
    join_none
    b = '{8'h40};
    for (int k = 0; k < 16; k++) begin
      roll();
      b.push_back(seed[7:0]);
    end
    xfer(b);
    chk(stretch_n > n0, 1);
    for (int i = 0; i < 4; i++) begin
      addr_select_pin = i[1];
      repeat (10) @(negedge clk);
      u_host.start();
      u_host.put({7'h3c + 7'(i[0]), 1'b1}, ack);
      chk(ack, i[0] == i[1]);
      if (ack === 1'b1) begin
        u_host.get(1'b0, rd);
        chk(rd, {en_x, col});
      end
      u_host.stop();
    end
    rst = 1'b1;
    repeat (3) @(negedge clk);
    chk({ram_wr_en, cmd_valid, oled_cmdset_enable, contrast_level}, 11'h07f);
    rst = 1'b0;
    en_x = 1'b0;
    con_x = 8'h7f;
    col = '0;
    repeat (5) @(negedge clk);
    xfer('{8'hc0, 8'h5a, 8'h40, 8'ha5});
    tally_and_finish();
  end
endmodule

// File: oic_fifo.sv
`timescale 1ns/1ns
module oic_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic  clk,
  input  wire logic  rst,
  oic_stream_if.snk  wr,
  oic_stream_if.src  rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wptr_r;
  logic [AW:0]      wptr_nxt;
  logic [AW:0]      rptr_r;
  logic [AW:0]      rptr_nxt;
  logic             full;
  logic             empty;
  logic             do_wr;
  logic             do_rd;

  // ----------------------------------------------------------------------
  // Pointers and flags
  // ----------------------------------------------------------------------
  always_comb begin
    empty    = (wptr_r == rptr_r);
    full     = (wptr_r[AW-1:0] == rptr_r[AW-1:0]) &&
               (wptr_r[AW] != rptr_r[AW]);
    do_wr    = wr.valid && !full;
    do_rd    = rd.ready && !empty;
    wptr_nxt = do_wr ? wptr_r + 1'b1 : wptr_r;
    rptr_nxt = do_rd ? rptr_r + 1'b1 : rptr_r;
    wr.ready = !full;
    rd.valid = !empty;
    rd.data  = mem_r[rptr_r[AW-1:0]];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_r[wptr_r[AW-1:0]] <= wr.data;
    end
  end
endmodule

// File: oic_host_model.sv
`timescale 1ns/1ns
module oic_host_model (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe,
  output logic      sda_oe
);
  int q = 4;

  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end

  task automatic hq();
    repeat (q) @(negedge clk);
  endtask

  // Releases the clock line and waits while the device stretches it.
  task automatic rise();
    int n;
    n = 0;
    scl_oe = 1'b0;
    while (scl !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    hq();
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_oe = !b;
    repeat (q / 2) @(negedge clk);
    rise();
    r = sda;
    scl_oe = 1'b1;
    repeat (q / 2) @(negedge clk);
  endtask

  task automatic start();
    sda_oe = 1'b0;
    hq();
    rise();
    sda_oe = 1'b1;
    hq();
    scl_oe = 1'b1;
    hq();
  endtask

  task automatic stop();
    sda_oe = 1'b1;
    hq();
    rise();
    sda_oe = 1'b0;
    hq();
  endtask

  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask

  task automatic get(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(!ack, r);
  endtask
endmodule

// File: oic_pkg.sv
package oic_pkg;

  // ----------------------------------------------------------------------
  // Addressing and framing
  // ----------------------------------------------------------------------
  localparam logic [5:0] ADDR_UPPER    = 6'h1e;
  localparam int         CO_BIT        = 7;
  localparam int         DC_BIT        = 6;
  localparam int         MSB_BIT       = 7;
  localparam logic       RW_READ       = 1'h1;
  localparam logic [3:0] BIT_LAST      = 4'h8;
  localparam logic [3:0] BIT_FIRST_TX  = 4'h1;
  localparam logic [3:0] BIT_NONE      = 4'h0;

  // ----------------------------------------------------------------------
  // Commands and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_CONTRAST  = 8'h81;
  localparam logic [7:0] CMD_OLED_ON   = 8'h79;
  localparam logic [7:0] CMD_OLED_OFF  = 8'h78;
  localparam logic [7:0] CONTRAST_RST  = 8'h7f;
  localparam logic [7:0] CONTRAST_MIN  = 8'h01;
  localparam logic [7:0] CONTRAST_ZERO = 8'h00;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int         COL_WIDTH     = 7;
  localparam logic [6:0] COL_RST       = 7'h00;
  localparam logic [6:0] COL_STEP      = 7'h01;
  localparam int         WORD_WIDTH    = 9;
  localparam int         FIFO_DEPTH    = 8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } oic_state_e;

endpackage

// File: oic_stream_if.sv
`timescale 1ns/1ns
interface oic_stream_if #(
  parameter int WIDTH = 9
);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
